// ==== rtl/dfx_effects.sv ====
// Purpose: Pixel effects stage of a 2D drawing engine.
// Assumes: One pixel per cycle when px_valid is high; inputs synchronous to mclk.
// Notes: Destination pixel is supplied with each source pixel; output lags by two cycles.
`include "dfx_defines.svh"

// How it works
// - Edge coverage blends with destination, only in direct color mode.
// - Line width accepted from 1 to 32 pixels.
// - Dash pattern length is selectable as 32 or 24 bits.
// - Anti-aliasing is disabled while a dash pattern is in use.
// - The transparent key is ignored by every alpha blend.
// - In direct color mode, register alpha applies one coefficient to every direct pixel of a primitive except anti-aliased edge pixels.
// - Vertex alpha is interpolated per pixel like shading.
// - Vertex alpha is only allowed in direct color mode.
// - Texel top bit set draws or blends; cleared may suppress the write.
// - Overlay blends with one coefficient latched per frame.
// - Gouraud color interpolation only in direct color mode.
// - Texture coordinates reach up to 4095 in each direction.
// - 8-bit targets force point sampling and de-curl blending.
// - Input pixels are 8-bit indexed or 16-bit direct.
module dfx_effects #(
	parameter int TEX_DIM = 4096
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Configuration
	input wire dfx_pkg::dfx_color_fmt_type target_fmt,
	input wire dfx_pkg::dfx_alpha_sel_type alpha_sel,
	input wire logic [7:0] reg_alpha,
	input wire logic aa_en,
	input wire logic gouraud_en,
	input wire logic tex_en,
	input wire logic tex_skip_en,
	input wire dfx_pkg::dfx_filter_type tex_filter_req,
	input wire dfx_pkg::dfx_tblend_type tex_blend_req,
	input wire logic [5:0] line_width_req,
	input wire logic dash_en,
	input wire logic dash_short,
	input wire logic [31:0] dash_pattern,
	// Primitive control
	input wire logic prim_start,
	input wire logic [7:0] alpha_start,
	input wire logic signed [8:0] alpha_step,
	input wire logic [15:0] color_start,
	input wire logic signed [15:0] color_step,
	// Pixel stream
	input wire logic px_valid,
	input wire dfx_pkg::dfx_color_fmt_type px_fmt,
	input wire logic [15:0] px_color,
	input wire logic [15:0] px_dst,
	input wire logic [3:0] px_cover,
	input wire logic [15:0] px_texel,
	input wire logic [12:0] tex_u,
	input wire logic [12:0] tex_v,
	// Overlay
	input wire logic frame_start,
	input wire logic [7:0] ovl_alpha,
	input wire logic ovl_valid,
	input wire logic [15:0] ovl_upper,
	input wire logic [15:0] ovl_lower,
	// Results
	output logic out_valid,
	output logic out_write,
	output logic [15:0] out_color,
	output logic ovl_out_valid,
	output logic [15:0] ovl_out_color,
	output logic [5:0] line_width,
	output dfx_pkg::dfx_filter_type tex_filter,
	output dfx_pkg::dfx_tblend_type tex_blend,
	output logic tex_range_err
);
	if (TEX_DIM < 1 || TEX_DIM > int'(`DFX_TEX_DIM_MAX)) begin : g_bad_dim
		$error("TEX_DIM out of range");
	end

	// *****************************************
	// Configuration qualification
	// *****************************************
	logic direct;
	logic aa_on;
	logic vtx_alpha_on;
	logic gouraud_on;
	logic [5:0] nxt_width;
	assign direct = (target_fmt == dfx_pkg::dfx_fmt_direct);
	assign aa_on = aa_en && direct && !dash_en;
	assign vtx_alpha_on = (alpha_sel == dfx_pkg::dfx_alpha_vertex) && direct;
	assign gouraud_on = gouraud_en && direct;
	always_comb begin
		nxt_width = line_width_req;
		if (line_width_req < `DFX_LINE_WIDTH_MIN) begin
			nxt_width = `DFX_LINE_WIDTH_MIN;
		end else if (line_width_req > `DFX_LINE_WIDTH_MAX) begin
			nxt_width = `DFX_LINE_WIDTH_MAX;
		end
	end
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			line_width <= `DFX_LINE_WIDTH_MIN;
			tex_filter <= dfx_pkg::dfx_filt_point;
			tex_blend <= dfx_pkg::dfx_tblend_decurl;
		end else if (ce) begin
			line_width <= nxt_width;
			tex_filter <= direct ? tex_filter_req : dfx_pkg::dfx_filt_point;
			tex_blend <= direct ? tex_blend_req : dfx_pkg::dfx_tblend_decurl;
		end
	end

	// *****************************************
	// Per-primitive interpolators and dash
	// *****************************************
	logic [7:0] alpha_acc_ff;
	logic [15:0] color_acc_ff;
	logic [4:0] dash_idx_ff;
	logic [5:0] dash_len;
	logic dash_on;
	assign dash_len = dash_short ? `DFX_DASH_LEN_SHORT : `DFX_DASH_LEN_LONG;
	assign dash_on = !dash_en || dash_pattern[dash_idx_ff];
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			alpha_acc_ff <= 8'h00;
			color_acc_ff <= 16'h0000;
		end else if (ce) begin
			if (prim_start) begin
				alpha_acc_ff <= alpha_start;
				color_acc_ff <= color_start;
			end else if (px_valid) begin
				alpha_acc_ff <= 8'($signed({1'b0, alpha_acc_ff}) + alpha_step);
				color_acc_ff <= color_acc_ff + 16'(color_step);
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			dash_idx_ff <= 5'h00;
		end else if (ce) begin
			if (prim_start) begin
				dash_idx_ff <= 5'h00;
			end else if (px_valid) begin
				dash_idx_ff <= (6'(dash_idx_ff) + 6'h01 >= dash_len) ? 5'h00 : dash_idx_ff + 5'h01;
			end
		end
	end

	// *****************************************
	// Pixel selection
	// *****************************************
	logic [15:0] src;
	logic [7:0] coef;
	logic write;
	logic tex_ok;
	assign tex_ok = (32'(tex_u) < TEX_DIM) && (32'(tex_v) < TEX_DIM);
	always_comb begin
		// Indexed pixels carry the code in the low byte and bypass blending.
		src = (px_fmt == dfx_pkg::dfx_fmt_direct) ? px_color : {8'h00, px_color[7:0]};
		if (gouraud_on) begin
			src = color_acc_ff;
		end
		if (tex_en) begin
			src = {1'b0, px_texel[14:0]};
		end
		coef = `DFX_ALPHA_FULL;
		if (alpha_sel == dfx_pkg::dfx_alpha_reg) begin
			coef = reg_alpha;
		end else if (vtx_alpha_on) begin
			coef = alpha_acc_ff;
		end
		if (aa_on && px_cover != 4'hf) begin
			coef = {px_cover, 4'h0};
		end
		if (!direct || px_fmt != dfx_pkg::dfx_fmt_direct) begin
			coef = `DFX_ALPHA_FULL;
		end
		write = dash_on;
		if (tex_en && tex_skip_en && !px_texel[`DFX_TEXEL_DRAW_BIT]) begin
			write = 1'b0;
		end
		if (tex_en && !tex_ok) begin
			write = 1'b0;
		end
		// No transparent-key compare: keyed colors blend like any other.
	end

	// *****************************************
	// Blend stage
	// *****************************************
	dfx_blend_if draw_bif ();
	dfx_blend_if ovl_bif ();
	logic [7:0] ovl_coef_ff;
	logic v1_ff;
	logic w1_ff;
	logic e1_ff;
	logic ov1_ff;
	assign draw_bif.src = src;
	assign draw_bif.dst = px_dst;
	assign draw_bif.coef = coef;
	assign ovl_bif.src = ovl_upper;
	assign ovl_bif.dst = ovl_lower;
	assign ovl_bif.coef = ovl_coef_ff;
	dfx_blender u_draw (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.bif(draw_bif)
	);
	dfx_blender u_ovl (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.bif(ovl_bif)
	);
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ovl_coef_ff <= 8'h00;
		end else if (ce && frame_start) begin
			ovl_coef_ff <= ovl_alpha;
		end
	end
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			v1_ff <= 1'b0;
			w1_ff <= 1'b0;
			e1_ff <= 1'b0;
			ov1_ff <= 1'b0;
			out_valid <= 1'b0;
			out_write <= 1'b0;
			out_color <= 16'h0000;
			ovl_out_valid <= 1'b0;
			ovl_out_color <= 16'h0000;
			tex_range_err <= 1'b0;
		end else if (ce) begin
			v1_ff <= px_valid;
			w1_ff <= px_valid && write;
			e1_ff <= px_valid && tex_en && !tex_ok;
			ov1_ff <= ovl_valid;
			out_valid <= v1_ff;
			out_write <= w1_ff;
			out_color <= draw_bif.mixed;
			ovl_out_valid <= ov1_ff;
			ovl_out_color <= ovl_bif.mixed;
			tex_range_err <= e1_ff;
		end
	end

	// *****************************************
	// Checks
	// *****************************************
	property p_width_range;
		@(posedge mclk) disable iff (!rstn)
		ce |=> (line_width >= `DFX_LINE_WIDTH_MIN && line_width <= `DFX_LINE_WIDTH_MAX);
	endproperty
	a_width_range: assert property (p_width_range) else $error("line width out of range");
	property p_dash_wrap;
		@(posedge mclk) disable iff (!rstn)
		(ce && dash_short && !prim_start) |=> (dash_idx_ff < 5'h18 || $past(dash_idx_ff) >= 5'h18);
	endproperty
	a_dash_wrap: assert property (p_dash_wrap) else $error("short dash pattern overran");
	property p_no_aa_dash;
		@(posedge mclk) disable iff (!rstn)
		(px_valid && dash_en && alpha_sel == dfx_pkg::dfx_alpha_off) |-> coef == `DFX_ALPHA_FULL;
	endproperty
	a_no_aa_dash: assert property (p_no_aa_dash) else $error("anti-aliasing on dashed line");
	property p_vtx_direct;
		@(posedge mclk) disable iff (!rstn)
		(px_valid && alpha_sel == dfx_pkg::dfx_alpha_vertex && !direct) |-> coef == `DFX_ALPHA_FULL;
	endproperty
	a_vtx_direct: assert property (p_vtx_direct) else $error("vertex alpha outside direct mode");
	property p_tex_skip;
		@(posedge mclk) disable iff (!rstn)
		(ce && px_valid && tex_en && tex_skip_en && !px_texel[`DFX_TEXEL_DRAW_BIT]) ##1 ce |=> !out_write;
	endproperty
	a_tex_skip: assert property (p_tex_skip) else $error("suppressed texel written");
	property p_ovl_hold;
		@(posedge mclk) disable iff (!rstn)
		(ce && !frame_start) |=> $stable(ovl_coef_ff);
	endproperty
	a_ovl_hold: assert property (p_ovl_hold) else $error("overlay coefficient changed mid frame");
	property p_indexed_pt;
		@(posedge mclk) disable iff (!rstn)
		(ce && !direct) |=> (tex_filter == dfx_pkg::dfx_filt_point && tex_blend == dfx_pkg::dfx_tblend_decurl);
	endproperty
	a_indexed_pt: assert property (p_indexed_pt) else $error("8-bit target texture mode wrong");
	property p_full_pass;
		@(posedge mclk) disable iff (!rstn)
		(ce && px_valid && coef == `DFX_ALPHA_FULL) ##1 ce ##1 ce |-> out_color == $past(src, 2);
	endproperty
	a_full_pass: assert property (p_full_pass) else $error("full coefficient altered source");
	property p_reg_alpha;
		@(posedge mclk) disable iff (!rstn)
		(px_valid && alpha_sel == dfx_pkg::dfx_alpha_reg && direct && px_fmt == dfx_pkg::dfx_fmt_direct && !aa_on)
			|-> coef == reg_alpha;
	endproperty
	a_reg_alpha: assert property (p_reg_alpha) else $error("register alpha not applied");
	property p_shade_idx;
		@(posedge mclk) disable iff (!rstn)
		(px_valid && gouraud_en && !direct && !tex_en && px_fmt == dfx_pkg::dfx_fmt_direct) |-> src == px_color;
	endproperty
	a_shade_idx: assert property (p_shade_idx) else $error("shading applied to 8-bit target");
	property p_tex_range;
		@(posedge mclk) disable iff (!rstn)
		(ce && px_valid && tex_en && (32'(tex_u) >= TEX_DIM || 32'(tex_v) >= TEX_DIM)) ##1 ce
			|=> (tex_range_err && !out_write);
	endproperty
	a_tex_range: assert property (p_tex_range) else $error("texture coordinate outside plane");
endmodule

// ==== rtl/dfx_defines.svh ====
// Purpose: Constants for the drawing effects pipeline.
// Assumes: Included by its bare name.
// Notes: Field positions refer to 16-bit direct color RGB565 pixels.
`ifndef DFX_DEFINES_SVH
`define DFX_DEFINES_SVH
`define DFX_LINE_WIDTH_MIN 6'h01
`define DFX_LINE_WIDTH_MAX 6'h20
`define DFX_DASH_LEN_LONG 6'h20
`define DFX_DASH_LEN_SHORT 6'h18
`define DFX_TEX_DIM_MAX 13'h1000
`define DFX_ALPHA_W 8
`define DFX_ALPHA_FULL 8'hff
`define DFX_RED_LSB 11
`define DFX_GRN_LSB 5
`define DFX_BLU_LSB 0
`define DFX_TEXEL_DRAW_BIT 15
`define DFX_FRAC_W 8
`define DFX_EDGE_W 4
`endif

// ==== rtl/dfx_pkg.sv ====
// Purpose: Types shared by the drawing effects pipeline.
// Assumes: Nothing is imported; users write dfx_pkg::name.
// Notes: Holds types only.
package dfx_pkg;
	typedef enum logic [1:0] {
		dfx_alpha_off,
		dfx_alpha_reg,
		dfx_alpha_vertex
	} dfx_alpha_sel_type;
	typedef enum logic [1:0] {
		dfx_filt_point,
		dfx_filt_bilinear
	} dfx_filter_type;
	typedef enum logic [1:0] {
		dfx_tblend_decurl,
		dfx_tblend_modulate,
		dfx_tblend_stencil
	} dfx_tblend_type;
	typedef enum logic {
		dfx_fmt_indexed,
		dfx_fmt_direct
	} dfx_color_fmt_type;
endpackage

// ==== rtl/dfx_blend_if.sv ====
// Purpose: Carries one blend request between the pipeline and its blender.
// Assumes: Single clock.
// Notes: The blender answers one cycle after the request.
interface dfx_blend_if;
	logic [15:0] src;
	logic [15:0] dst;
	logic [7:0] coef;
	logic [15:0] mixed;
	modport master (output src, output dst, output coef, input mixed);
	modport slave (input src, input dst, input coef, output mixed);
endinterface

// ==== rtl/dfx_blender.sv ====
// Purpose: Per-channel alpha blend of two RGB565 pixels.
// Assumes: Coefficient 8'hff means all source.
// Notes: Result is registered; latency one cycle.
`include "dfx_defines.svh"
module dfx_blender (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Blend request
	dfx_blend_if.slave bif
);
	// *****************************************
	// Channel mix
	// *****************************************
	function automatic logic [5:0] mix_ch(input logic [5:0] s, input logic [5:0] d, input logic [7:0] a);
		logic [15:0] acc;
		acc = 16'(s) * 16'(a) + 16'(d) * 16'(8'hff - a) + 16'h007f;
		mix_ch = 6'(acc / 16'h00ff);
	endfunction

	logic [15:0] mixed_ff;
	logic [15:0] nxt_mixed;
	always_comb begin
		nxt_mixed[15:11] = 5'(mix_ch({1'b0, bif.src[15:11]}, {1'b0, bif.dst[15:11]}, bif.coef));
		nxt_mixed[10:5] = mix_ch(bif.src[10:5], bif.dst[10:5], bif.coef);
		nxt_mixed[4:0] = 5'(mix_ch({1'b0, bif.src[4:0]}, {1'b0, bif.dst[4:0]}, bif.coef));
	end
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mixed_ff <= 16'h0000;
		end else if (ce) begin
			mixed_ff <= nxt_mixed;
		end
	end
	assign bif.mixed = mixed_ff;
endmodule

// ==== bench/test_dfx_effects.sv ====
// Purpose: Self-checking bench for the drawing effects pipeline.
// Assumes: Pixel results two edges after the request, settings one edge after.
// Notes: Pixels are sent one at a time so each result can be judged alone.
module test_dfx_effects;
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// Signals
	// ****************************************
	logic mclk, rstn, ce;
	dfx_pkg::dfx_color_fmt_type target_fmt, px_fmt;
	dfx_pkg::dfx_alpha_sel_type alpha_sel;
	dfx_pkg::dfx_filter_type tex_filter_req, tex_filter;
	dfx_pkg::dfx_tblend_type tex_blend_req, tex_blend;
	logic [7:0] reg_alpha, alpha_start, ovl_alpha;
	logic aa_en, gouraud_en, tex_en, tex_skip_en, dash_en, dash_short;
	logic prim_start, px_valid, frame_start, ovl_valid, seen_err;
	logic [5:0] line_width_req, line_width;
	logic [31:0] dash_pattern;
	logic signed [8:0] alpha_step;
	logic signed [15:0] color_step;
	logic [15:0] color_start, px_color, px_dst, px_texel, ovl_upper, ovl_lower, out_color, ovl_out_color;
	logic [3:0] px_cover;
	logic [12:0] tex_u, tex_v;
	logic out_valid, out_write, ovl_out_valid, tex_range_err;
	int num_errors, comparisons;
	dfx_effects #(.TEX_DIM(4096)) i_dut (.mclk, .rstn, .ce, .target_fmt, .alpha_sel, .reg_alpha, .aa_en,
		.gouraud_en, .tex_en, .tex_skip_en, .tex_filter_req, .tex_blend_req, .line_width_req, .dash_en,
		.dash_short, .dash_pattern, .prim_start, .alpha_start, .alpha_step, .color_start, .color_step,
		.px_valid, .px_fmt, .px_color, .px_dst, .px_cover, .px_texel, .tex_u, .tex_v, .frame_start,
		.ovl_alpha, .ovl_valid, .ovl_upper, .ovl_lower, .out_valid, .out_write, .out_color, .ovl_out_valid,
		.ovl_out_color, .line_width, .tex_filter, .tex_blend, .tex_range_err);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] mix(input logic [15:0] s, input logic [15:0] d, input logic [7:0] a);
		int k;
		k = a;
		mix[15:11] = 5'((s[15:11] * k + d[15:11] * (255 - k) + 127) / 255);
		mix[10:5] = 6'((s[10:5] * k + d[10:5] * (255 - k) + 127) / 255);
		mix[4:0] = 5'((s[4:0] * k + d[4:0] * (255 - k) + 127) / 255);
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	task automatic stop_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// One pixel; the result is judged two edges after it is taken.
	task automatic px(input logic [15:0] c, input logic [3:0] cv, input logic [15:0] t, input logic [12:0] u,
		input logic ew, input logic [15:0] ec, input logic cc);
		@(negedge mclk);
		px_valid = 1'b1;
		px_color = c;
		px_cover = cv;
		px_texel = t;
		tex_u = u;
		seen_err = 1'b0;
		repeat (2) begin
			@(negedge mclk);
			px_valid = 1'b0;
			seen_err = seen_err | tex_range_err;
		end
		chk("out_valid", 16'h0001, 16'(out_valid));
		chk("out_write", 16'(ew), 16'(out_write));
		if (cc) begin
			chk("out_color", ec, out_color);
		end
	endtask
	task automatic prim(input logic [7:0] a, input logic signed [8:0] s);
		@(negedge mclk);
		prim_start = 1'b1;
		alpha_start = a;
		alpha_step = s;
		@(negedge mclk);
		prim_start = 1'b0;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		chk("line_width", 16'h0001, 16'(line_width));
		chk("tex_filter", 16'(dfx_pkg::dfx_filt_point), 16'(tex_filter));
		chk("tex_blend", 16'(dfx_pkg::dfx_tblend_decurl), 16'(tex_blend));
		chk("out_valid", 16'h0000, 16'(out_valid));
		chk("ovl_out_valid", 16'h0000, 16'(ovl_out_valid));
		$display("test reset done");
	endtask
	task automatic t_width;
		logic [5:0] rq[5];
		logic [5:0] ex[5];
		rq = '{6'h00, 6'h01, 6'h20, 6'h21, 6'h3f};
		ex = '{6'h01, 6'h01, 6'h20, 6'h20, 6'h20};
		for (int i = 0; i < 5; i++) begin
			@(negedge mclk);
			line_width_req = rq[i];
			@(negedge mclk);
			chk("line_width", 16'(ex[i]), 16'(line_width));
		end
		$display("test width done");
	endtask
	task automatic t_texmode;
		for (int k = 0; k < 2; k++) begin
			for (int j = 0; j < 3; j++) begin
				@(negedge mclk);
				target_fmt = dfx_pkg::dfx_color_fmt_type'(k);
				tex_filter_req = dfx_pkg::dfx_filter_type'(j % 2);
				tex_blend_req = dfx_pkg::dfx_tblend_type'(j);
				@(negedge mclk);
				chk("tex_filter", 16'(k == 0 ? 0 : j % 2), 16'(tex_filter));
				chk("tex_blend", 16'(k == 0 ? 0 : j), 16'(tex_blend));
			end
		end
		$display("test texture mode done");
	endtask
	task automatic t_blend;
		alpha_sel = dfx_pkg::dfx_alpha_reg;
		reg_alpha = 8'h40;
		px(16'hf800, 4'hf, 16'h0000, 13'h0000, 1'b1, mix(16'hf800, 16'h07ff, 8'h40), 1'b1);
		px(16'h07e0, 4'hf, 16'h0000, 13'h0000, 1'b1, mix(16'h07e0, 16'h07ff, 8'h40), 1'b1);
		px_fmt = dfx_pkg::dfx_fmt_indexed;
		px(16'h0012, 4'hf, 16'h0000, 13'h0000, 1'b1, 16'h0012, 1'b1);
		px_fmt = dfx_pkg::dfx_fmt_direct;
		alpha_sel = dfx_pkg::dfx_alpha_vertex;
		reg_alpha = 8'hff;
		prim(8'h40, 9'sh020);
		px(16'hf800, 4'hf, 16'h0000, 13'h0000, 1'b1, mix(16'hf800, 16'h07ff, 8'h40), 1'b1);
		px(16'hf800, 4'hf, 16'h0000, 13'h0000, 1'b1, mix(16'hf800, 16'h07ff, 8'h60), 1'b1);
		target_fmt = dfx_pkg::dfx_fmt_indexed;
		prim(8'h40, 9'sh020);
		px(16'hf800, 4'hf, 16'h0000, 13'h0000, 1'b1, 16'hf800, 1'b1);
		target_fmt = dfx_pkg::dfx_fmt_direct;
		alpha_sel = dfx_pkg::dfx_alpha_off;
		$display("test blend done");
	endtask
	task automatic t_edges;
		aa_en = 1'b1;
		px(16'hf800, 4'h8, 16'h0000, 13'h0000, 1'b1, mix(16'hf800, 16'h07ff, 8'h80), 1'b1);
		target_fmt = dfx_pkg::dfx_fmt_indexed;
		px(16'h00f8, 4'h8, 16'h0000, 13'h0000, 1'b1, 16'h00f8, 1'b1);
		target_fmt = dfx_pkg::dfx_fmt_direct;
		dash_en = 1'b1;
		dash_pattern = 32'hffff_ffff;
		px(16'hf800, 4'h8, 16'h0000, 13'h0000, 1'b1, 16'hf800, 1'b1);
		aa_en = 1'b0;
		// Only the low 24 pattern bits are set, so the short length shows as a wrap.
		dash_pattern = 32'h00ff_ffff;
		for (int s = 0; s < 2; s++) begin
			dash_short = s[0];
			prim(8'h00, 9'sh000);
			for (int i = 0; i < 25; i++) begin
				px(16'h001f, 4'hf, 16'h0000, 13'h0000, s == 1 || i < 24, 16'h001f, 1'b0);
			end
		end
		dash_en = 1'b0;
		$display("test edges and dashes done");
	endtask
	task automatic t_texel;
		tex_en = 1'b1;
		tex_skip_en = 1'b1;
		px(16'h0000, 4'hf, 16'h7abc, 13'h0000, 1'b0, 16'h0000, 1'b0);
		px(16'h0000, 4'hf, 16'h8abc, 13'h0fff, 1'b1, 16'h0abc, 1'b1);
		chk("tex_range_err", 16'h0000, 16'(seen_err));
		tex_skip_en = 1'b0;
		px(16'h0000, 4'hf, 16'h7abc, 13'h0000, 1'b1, 16'h0000, 1'b0);
		px(16'h0000, 4'hf, 16'h8abc, 13'h1000, 1'b0, 16'h0000, 1'b0);
		chk("tex_range_err", 16'h0001, 16'(seen_err));
		tex_v = 13'h1000;
		px(16'h0000, 4'hf, 16'h8abc, 13'h0000, 1'b0, 16'h0000, 1'b0);
		chk("tex_range_err", 16'h0001, 16'(seen_err));
		tex_v = 13'h0000;
		tex_en = 1'b0;
		$display("test texel done");
	endtask
	task automatic t_overlay;
		@(negedge mclk);
		frame_start = 1'b1;
		ovl_alpha = 8'h80;
		@(negedge mclk);
		frame_start = 1'b0;
		ovl_alpha = 8'h10;
		ovl_valid = 1'b1;
		ovl_upper = 16'hf800;
		ovl_lower = 16'h001f;
		@(negedge mclk);
		ovl_valid = 1'b0;
		@(negedge mclk);
		chk("ovl_out_valid", 16'h0001, 16'(ovl_out_valid));
		chk("ovl_out_color", mix(16'hf800, 16'h001f, 8'h80), ovl_out_color);
		$display("test overlay done");
	endtask
	task automatic t_shade;
		gouraud_en = 1'b1;
		color_start = 16'h1000;
		color_step = 16'sh0021;
		prim(8'h00, 9'sh000);
		px(16'hf800, 4'hf, 16'h0000, 13'h0000, 1'b1, 16'h1000, 1'b1);
		px(16'hf800, 4'hf, 16'h0000, 13'h0000, 1'b1, 16'h1021, 1'b1);
		target_fmt = dfx_pkg::dfx_fmt_indexed;
		px(16'hf800, 4'hf, 16'h0000, 13'h0000, 1'b1, 16'hf800, 1'b1);
		target_fmt = dfx_pkg::dfx_fmt_direct;
		gouraud_en = 1'b0;
		$display("test shading done");
	endtask
	// A pixel offered while the enable is low must never be taken.
	task automatic t_freeze;
		@(negedge mclk);
		ce = 1'b0;
		px_valid = 1'b1;
		line_width_req = 6'h05;
		repeat (2) @(negedge mclk);
		chk("out_valid", 16'h0000, 16'(out_valid));
		chk("line_width", 16'h0020, 16'(line_width));
		ce = 1'b1;
		px_valid = 1'b0;
		@(negedge mclk);
		chk("line_width", 16'h0005, 16'(line_width));
		repeat (2) @(negedge mclk);
		chk("out_valid", 16'h0000, 16'(out_valid));
		$display("test clock enable done");
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		{rstn, aa_en, gouraud_en, tex_en, tex_skip_en, dash_en, dash_short, prim_start} = '0;
		{px_valid, frame_start, ovl_valid, seen_err, reg_alpha, alpha_start, ovl_alpha} = '0;
		{line_width_req, dash_pattern, alpha_step, color_step, color_start, px_color} = '0;
		{px_texel, ovl_upper, ovl_lower, px_cover, tex_u, tex_v} = '0;
		ce = 1'b1;
		px_dst = 16'h07ff;
		num_errors = 0;
		comparisons = 0;
		target_fmt = dfx_pkg::dfx_fmt_direct;
		px_fmt = dfx_pkg::dfx_fmt_direct;
		alpha_sel = dfx_pkg::dfx_alpha_off;
		tex_filter_req = dfx_pkg::dfx_filt_point;
		tex_blend_req = dfx_pkg::dfx_tblend_decurl;
		repeat (2) @(negedge mclk);
		rstn = 1'b1;
		t_reset();
		t_width();
		t_texmode();
		t_blend();
		t_shade();
		t_edges();
		t_texel();
		t_overlay();
		t_freeze();
		stop_test();
	end
endmodule
